//--- verilog/tms_defines.vh
`ifndef TMS_DEFINES_VH
`define TMS_DEFINES_VH
// ==========================================================
// character codes
`define TMS_CODE_ESC      7'h1B
`define TMS_CODE_SPACE    7'h20
`define TMS_CODE_DEL      7'h7F
`define TMS_CODE_SYM_ON   7'h46
`define TMS_CODE_SYM_OFF  7'h47
`define TMS_CODE_PLOT_ON  7'h31
`define TMS_CODE_PLOT_OFF 7'h32
`define TMS_CODE_LOWER_LO 7'h60
// ==========================================================
// mode encodings
`define TMS_MODE_TEXT   2'h0
`define TMS_MODE_SYMBOL 2'h1
`define TMS_MODE_PLOT   2'h2
// ==========================================================
// route encodings
`define TMS_ROUTE_TEXT    2'h0
`define TMS_ROUTE_SYMBOL  2'h1
`define TMS_ROUTE_PLOT    2'h2
`define TMS_ROUTE_CONTROL 2'h3
`endif

//--- verilog/tms_skid_buffer.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-entry buffer
module tms_skid_buffer #(
  parameter WIDTH = 16
) (
  input  wire             ref_clk,
  input  wire             rst_b,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem_r [0:1];
  reg             wrPtr_r;
  reg             rdPtr_r;
  reg [1:0]       count_r;
  wire            doWr;
  wire            doRd;

  assign inReady  = (count_r != 2'h2);
  assign outValid = (count_r != 2'h0);
  assign outData  = mem_r[rdPtr_r];
  assign doWr     = inValid & inReady;
  assign doRd     = outValid & outReady;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r  <= 1'b0;
      rdPtr_r  <= 1'b0;
      count_r  <= 2'h0;
      mem_r[0] <= {WIDTH{1'b0}};
      mem_r[1] <= {WIDTH{1'b0}};
    end else begin
      if (doWr) begin
        mem_r[wrPtr_r] <= inData;
        wrPtr_r        <= ~wrPtr_r;
      end
      if (doRd) begin
        rdPtr_r <= ~rdPtr_r;
      end
      if (doWr && !doRd) begin
        count_r <= count_r + 2'h1;
      end else if (doRd && !doWr) begin
        count_r <= count_r - 2'h1;
      end
    end
  end
endmodule // tms_skid_buffer
`default_nettype wire

//--- verilog/tms_terminal_mode_sequencer.v
// Overview of operation
// RULE1 - escape then F enters symbol mode; lowercase codes pick symbols
// RULE2 - control codes in symbol mode run and symbol mode is kept
// RULE3 - escape in symbol mode is temporary; afterwards symbol mode resumes
// RULE4 - escape then G in symbol mode switches to plain text mode
// RULE5 - escape then 1 from text or symbol enters plotting, origin recorded
// RULE6 - printable characters while plotting go to the plotting logic
// RULE7 - control codes while plotting run and plotting mode is kept
// RULE8 - escape while plotting is temporary; afterwards plotting resumes
// RULE9 - escape then 2 while plotting returns to the recorded mode
// RULE10 - only escape then 2 leaves plotting; F and G ignored there
// RULE11 - control functions never change the lasting mode
// RULE12 - restart forces plain text mode from any mode
// RULE13 - in escape state the single next character is examined
// RULE14 - undefined escape pairs are discarded, prior lasting mode kept (code forwards them on the control route with the escape flag set)
// RULE15 - reset clears recorded origin to text and any pending escape
// RULE16 - seven-bit codes; below space is control; escape starts a pair
`timescale 1ns/1ps
`default_nettype none
`include "tms_defines.vh"
module tms_terminal_mode_sequencer #(
  parameter CODE_W = 7
) (
  input  wire              ref_clk,
  input  wire              rst_b,
  input  wire              logicRestart,
  input  wire              rxValid,
  output wire              rxReady,
  input  wire [CODE_W-1:0] rxChar,
  output wire              outValid,
  input  wire              outReady,
  output wire [1:0]        outRoute,
  output wire [CODE_W-1:0] outChar,
  output wire              outEscSeq,
  output reg  [1:0]        modeState_r,
  output reg               escPending_r,
  output reg               plotFromSymbol_r,
  output reg               symbolSelect_r
);
  // ==========================================================
  // lasting modes
  localparam [1:0] ST_TEXT   = `TMS_MODE_TEXT;
  localparam [1:0] ST_SYMBOL = `TMS_MODE_SYMBOL;
  localparam [1:0] ST_PLOT   = `TMS_MODE_PLOT;

  // ==========================================================
  // classification
  wire              isEsc;
  wire              isCtrl;
  wire              isSymCode;
  wire              isSymOn;
  wire              isSymOff;
  wire              isPlotOn;
  wire              isPlotOff;
  wire              take;
  wire              bufReady;
  // buffer word: escape flag, route, code
  wire [CODE_W+2:0] bufIn;
  wire [CODE_W+2:0] bufOut;

  reg  [1:0]        route;
  reg               fwd;
  reg               fwdEsc;
  // next state
  reg  [1:0]        mode_nxt;
  reg               esc_nxt;
  reg               from_nxt;

  // escape pair outcome
  reg  [1:0]        pairMode;
  reg               pairFrom;
  reg               pairFwd;

  // route of a plain character
  reg  [1:0]        plainRoute;

  assign rxReady   = bufReady;
  assign take      = rxValid & bufReady;
  assign isEsc     = (rxChar == `TMS_CODE_ESC); // RULE16
  assign isCtrl    = (rxChar < `TMS_CODE_SPACE); // RULE16
  assign isSymCode = (rxChar >= `TMS_CODE_LOWER_LO) &&
                     (rxChar != `TMS_CODE_DEL);
  // pair codes
  assign isSymOn   = (rxChar == `TMS_CODE_SYM_ON);
  assign isSymOff  = (rxChar == `TMS_CODE_SYM_OFF);
  assign isPlotOn  = (rxChar == `TMS_CODE_PLOT_ON);
  assign isPlotOff = (rxChar == `TMS_CODE_PLOT_OFF);

  // ==========================================================
  // escape pair decode
  always @* begin
    pairMode = modeState_r;
    pairFrom = plotFromSymbol_r;
    pairFwd  = 1'b0;
    case (modeState_r)
      ST_TEXT: begin
        if (isSymOn) begin
          pairMode = ST_SYMBOL; // RULE1
        end else if (isPlotOn) begin
          pairMode = ST_PLOT; // RULE5
          pairFrom = 1'b0; // RULE5
        end else if (!isSymOff && !isPlotOff) begin
          pairFwd = 1'b1; // RULE14
        end
      end
      ST_SYMBOL: begin
        if (isSymOff) begin
          pairMode = ST_TEXT; // RULE4
        end else if (isPlotOn) begin
          pairMode = ST_PLOT; // RULE5
          pairFrom = 1'b1; // RULE5
        end else if (!isSymOn && !isPlotOff) begin
          pairFwd = 1'b1; // RULE3
        end
      end
      ST_PLOT: begin
        if (isPlotOff) begin
          pairMode = plotFromSymbol_r ? ST_SYMBOL : ST_TEXT; // RULE9
        end else if (isSymOn || isSymOff || isPlotOn) begin
          // F, G and 1 swallowed while plotting
          pairFwd = 1'b0; // RULE10
        end else begin
          pairFwd = 1'b1; // RULE8
        end
      end
      default: begin
        pairMode = ST_TEXT;
      end
    endcase
  end

  // ==========================================================
  // plain character routing
  always @* begin
    // control codes never change the mode
    if (isCtrl) begin
      plainRoute = `TMS_ROUTE_CONTROL; // RULE2 RULE7 RULE11
    end else begin
      case (modeState_r)
        ST_PLOT: begin
          plainRoute = `TMS_ROUTE_PLOT; // RULE6
        end
        ST_SYMBOL: begin
          plainRoute = isSymCode ? `TMS_ROUTE_SYMBOL
                                 : `TMS_ROUTE_TEXT; // RULE1
        end
        default: begin
          plainRoute = `TMS_ROUTE_TEXT;
        end
      endcase
    end
  end

  // ==========================================================
  // mode transitions
  always @* begin
    mode_nxt = modeState_r;
    esc_nxt  = escPending_r;
    from_nxt = plotFromSymbol_r;
    route    = `TMS_ROUTE_TEXT;
    fwd      = 1'b0;
    fwdEsc   = 1'b0;
    if (take) begin
      if (escPending_r) begin
        esc_nxt  = 1'b0; // RULE13
        route    = `TMS_ROUTE_CONTROL;
        mode_nxt = pairMode;
        from_nxt = pairFrom;
        fwd      = pairFwd; // RULE14
        fwdEsc   = pairFwd;
      end else if (isEsc) begin
        // escape itself is swallowed
        esc_nxt = 1'b1; // RULE3 RULE8
      end else begin
        route = plainRoute;
        fwd   = 1'b1;
      end
    end
    // restart wins over any character taken this cycle
    if (logicRestart) begin
      mode_nxt = ST_TEXT; // RULE12
      esc_nxt  = 1'b0; // RULE12
      from_nxt = 1'b0;
      fwd      = 1'b0;
      fwdEsc   = 1'b0;
    end
  end

  // ==========================================================
  // state registers
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      modeState_r      <= `TMS_MODE_TEXT;
      escPending_r     <= 1'b0; // RULE15
      plotFromSymbol_r <= 1'b0; // RULE15
      symbolSelect_r   <= 1'b0;
    end else begin
      modeState_r      <= mode_nxt;
      escPending_r     <= esc_nxt;
      plotFromSymbol_r <= from_nxt;
      symbolSelect_r   <= (mode_nxt == `TMS_MODE_SYMBOL);
    end
  end

  // ==========================================================
  // output buffer
  assign bufIn                          = {fwdEsc, route, rxChar};
  assign {outEscSeq, outRoute, outChar} = bufOut;

  tms_skid_buffer #(
    .WIDTH (CODE_W + 3)
  ) uBuf (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .inValid  (fwd),
    .inReady  (bufReady),
    .inData   (bufIn),
    .outValid (outValid),
    .outReady (outReady),
    .outData  (bufOut)
  );
endmodule // tms_terminal_mode_sequencer
`default_nettype wire

//--- tb/tms_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tms_checker #(parameter CODE_W = 7) (
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire logic              logicRestart,
  input wire logic              rxValid,
  input wire logic              rxReady,
  input wire logic [CODE_W-1:0] rxChar,
  input wire logic              outValid,
  input wire logic [1:0]        outRoute,
  input wire logic [CODE_W-1:0] outChar,
  input wire logic [1:0]        modeState_r,
  input wire logic              escPending_r,
  input wire logic              plotFromSymbol_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire tk = rxValid && rxReady && !logicRestart;
  wire ek = tk && escPending_r;
  wire pl = modeState_r == 2'h2;
  wire pr = rxChar >= 7'h20 && rxChar < 7'h7F;
  property p_rst; logicRestart |=> !pl && !modeState_r[0] && !escPending_r;
  endproperty
  a_rst: assert property (p_rst) else $error("restart");
  property p_esc; tk && !escPending_r && rxChar == 7'h1B |=> escPending_r;
  endproperty
  a_esc: assert property (p_esc) else $error("escape");
  property p_one; ek |=> !escPending_r; endproperty
  a_one: assert property (p_one) else $error("pair length");
  property p_sym; ek && !pl && rxChar == 7'h46 |=> modeState_r == 2'h1;
  endproperty
  a_sym: assert property (p_sym) else $error("symbol on");
  property p_txt; ek && modeState_r == 2'h1 && rxChar == 7'h47 |=>
    modeState_r == 2'h0; endproperty
  a_txt: assert property (p_txt) else $error("symbol off");
  property p_pon; ek && !pl && rxChar == 7'h31 |=>
    pl && plotFromSymbol_r == $past(modeState_r[0]); endproperty
  a_pon: assert property (p_pon) else $error("plot on");
  property p_poff; ek && pl && rxChar == 7'h32 |=>
    modeState_r == {1'b0, $past(plotFromSymbol_r)}; endproperty
  a_poff: assert property (p_poff) else $error("plot off");
  property p_stay; ek && pl && rxChar != 7'h32 |=> pl; endproperty
  a_stay: assert property (p_stay) else $error("plot left");
  property p_keep; !ek && !logicRestart |=> $stable(modeState_r); endproperty
  a_keep: assert property (p_keep) else $error("mode moved");
  property p_plot; tk && !escPending_r && pl && pr && !outValid |=>
    outValid && outRoute == 2'h2 && outChar == $past(rxChar); endproperty
  a_plot: assert property (p_plot) else $error("plot route");
endmodule // tms_checker
bind tms_terminal_mode_sequencer tms_checker #(.CODE_W(CODE_W)) chk_u (
  .ref_clk          (ref_clk),
  .rst_b            (rst_b),
  .logicRestart     (logicRestart),
  .rxValid          (rxValid),
  .rxReady          (rxReady),
  .rxChar           (rxChar),
  .outValid         (outValid),
  .outRoute         (outRoute),
  .outChar          (outChar),
  .modeState_r      (modeState_r),
  .escPending_r     (escPending_r),
  .plotFromSymbol_r (plotFromSymbol_r)
);
`default_nettype wire

//--- tb/tms_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tms_host_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       rxReady,
  output var  logic       rxValid,
  output var  logic [6:0] rxChar
);
  logic [6:0] q[$];
  // holds each char until taken; idle line toggles
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxValid <= 1'b0;
      rxChar  <= 7'h00;
    end else if (!rxValid || rxReady) begin
      rxValid <= q.size() > 0;
      rxChar <= (q.size() > 0) ? q.pop_front() : ~rxChar;
    end
  end
endmodule // tms_host_model
`default_nettype wire

//--- tb/tms_testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0, rst_b = 1'b0, logicRestart = 1'b0, outReady = 1'b1;
  wire rxValid, rxReady, outValid, outEscSeq, escP, fromS, symS;
  wire [6:0] rxChar, outChar;
  wire [1:0] outRoute, mode;
  int n_errors = 0, n_compared = 0, cyc = 0;
  logic [9:0] got[$];
  initial forever #12.5 ref_clk = ~ref_clk;
  tms_host_model host_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .rxReady(rxReady), .rxValid(rxValid), .rxChar(rxChar));
  tms_terminal_mode_sequencer dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .logicRestart(logicRestart), .rxValid(rxValid), .rxReady(rxReady),
    .rxChar(rxChar), .outValid(outValid), .outReady(outReady),
    .outRoute(outRoute), .outChar(outChar), .outEscSeq(outEscSeq),
    .modeState_r(mode), .escPending_r(escP), .plotFromSymbol_r(fromS),
    .symbolSelect_r(symS));
  always @(posedge ref_clk)
    if (outValid && outReady) got.push_back({outRoute, outChar, outEscSeq});
  task automatic fail(input string s);
    n_errors++;
    $display("[FAIL] %0t %s", $time, s);
  endtask
  task automatic chk_bit(input logic g, e);
    n_compared++;
    if (g !== e) fail("flag mismatch");
  endtask
  task automatic chk_mode(input logic [1:0] m);
    n_compared++;
    if ({mode, symS} !== {m, m == 2'h1}) fail("mode mismatch");
  endtask
  task automatic chk_word(input logic [1:0] r, input logic [6:0] c,
                          input logic e);
    logic [9:0] w;
    w = got.size() > 0 ? got.pop_front() : 10'bx;
    n_compared++;
    if (w !== {r, c, e}) fail("word mismatch");
  endtask
  task automatic snd(input logic [6:0] c);
    host_u.q.push_back(c);
  endtask
  task automatic drain();
    for (int i = 0; i < 50 && (host_u.q.size() > 0 || rxValid); i++)
      @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_symbol();
    snd(7'h1B); snd(7'h46); snd(7'h61); snd(7'h0A); snd(7'h1B); snd(7'h5A);
    drain();
    chk_mode(2'h1);
    chk_word(2'h1, 7'h61, 1'b0);
    chk_word(2'h3, 7'h0A, 1'b0);
    chk_word(2'h3, 7'h5A, 1'b1);
    $display("symbol test done");
  endtask
  task automatic t_plot();
    snd(7'h1B); snd(7'h31); snd(7'h41); snd(7'h0D);
    snd(7'h1B); snd(7'h46); snd(7'h1B); snd(7'h47);
    drain();
    chk_mode(2'h2);
    chk_bit(fromS, 1'b1);
    chk_word(2'h2, 7'h41, 1'b0);
    chk_word(2'h3, 7'h0D, 1'b0);
    snd(7'h1B); snd(7'h32);
    drain();
    chk_mode(2'h1);
    snd(7'h1B); snd(7'h47);
    snd(7'h1B); snd(7'h31); snd(7'h1B); snd(7'h32);
    drain();
    chk_mode(2'h0);
    chk_bit(got.size() == 0, 1'b1);
    $display("plot test done");
  endtask
  task automatic t_stall();
    @(posedge ref_clk) outReady <= 1'b0;
    snd(7'h61); snd(7'h62); snd(7'h63);
    repeat (10) @(posedge ref_clk);
    #1;
    chk_bit(rxReady, 1'b0);
    chk_bit(rxValid, 1'b1);
    @(posedge ref_clk) outReady <= 1'b1;
    drain();
    chk_word(2'h0, 7'h61, 1'b0);
    chk_word(2'h0, 7'h62, 1'b0);
    chk_word(2'h0, 7'h63, 1'b0);
    $display("stall test done");
  endtask
  task automatic t_restart();
    snd(7'h1B); snd(7'h31); snd(7'h1B);
    drain();
    chk_bit(escP, 1'b1);
    @(posedge ref_clk) logicRestart <= 1'b1;
    @(posedge ref_clk) logicRestart <= 1'b0;
    @(posedge ref_clk) #1;
    chk_mode(2'h0);
    chk_bit(escP, 1'b0);
    $display("restart test done");
  endtask
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk) #1;
    chk_mode(2'h0);
    chk_bit(escP | fromS | outValid, 1'b0);
    chk_bit(rxReady, 1'b1);
    $display("reset test done");
    t_symbol();
    t_plot();
    t_stall();
    t_restart();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
